// ==== logic/scx_exec.sv ====
// executor for negate, no-operation, pop, push, relative call and reset instructions
// assumes program memory returns instr_word for program_counter during phase one, and the
// file register array returns fr_rd_data in phase three, one cycle after the read strobe
//
// Notes on behaviour
// - negate is one word, one cycle, reading its register in phase two and writing it in phase four.
// - pop discards the top stack entry in phase three of a single cycle.
// - after a pop the previous entry is on top, the program counter steps by two and flags are untouched.
// - push places program counter plus two on the stack in phase two, one cycle, no flag change.
// - push moves the old top one level down so it stays retrievable.
// - words starting 1101 1 are relative calls with an 11-bit signed word offset.
// - the call offset is two's complement from -1024 to 1023.
// - a call pushes program counter plus two in phase two of its first cycle.
// - a call loads program counter plus two plus twice the offset in phase four, then idles a cycle.
// - a call is one word, exactly two cycles, and changes no flag.
// - the reset word starts in phase two the same reset as the master clear pin.
`timescale 1ns/1ps

module scx_exec
  import scx_pkg::*;
(
  // clock and reset (reset is the master clear)
  input wire logic core_clk,
  input wire logic rst_b,
  // program memory
  input wire logic [WORD_W-1:0] instr_word,
  output logic [PC_W-1:0] program_counter,
  output scx_phase_e phase,
  // file register access
  input wire logic [DATA_W-1:0] fr_rd_data,
  output scx_freq_s fr_req,
  // core state
  output logic [PC_W-1:0] top_of_stack,
  output scx_flags_s status_flags,
  output logic reset_instr_req
);

  // ==========================================================
  // functions

  // decode of one program word into an operation
  // the no-op test comes first so a word with top nibble 1111 can never
  // alias a later pattern; any unlisted word falls through to a plain no-op
  // and so only steps the program counter
  function automatic scx_op_e decode_op(input logic [WORD_W-1:0] w);
    scx_op_e op;
    op = OP_NOP;
    if (w == NOP_ZERO || (w & NOP_MASK) == NOP_MATCH) begin
      op = OP_NOP;
    end else if ((w & NEG_MASK) == NEG_MATCH) begin
      op = OP_NEG;
    end else if (w == POP_WORD) begin
      op = OP_POP;
    end else if (w == PUSH_WORD) begin
      op = OP_PUSH;
    end else if (w == RESET_WORD) begin
      op = OP_RESET;
    end else if ((w & CALL_MASK) == CALL_MATCH) begin
      op = OP_CALL;
    end
    return op;
  endfunction

  // relative call target from the current address and the offset field
  // the offset is sign extended to the full counter width and added twice,
  // which doubles it into a byte step without a shift of a signed value;
  // the sum wraps at the top of the address space like the counter itself
  function automatic logic [PC_W-1:0] call_target(input logic [PC_W-1:0] pc,
                                                  input logic [WORD_W-1:0] w);
    logic signed [CALL_OFS_W-1:0] ofs;
    logic [PC_W-1:0] ext;
    ofs = signed'(w[CALL_OFS_LSB +: CALL_OFS_W]);
    ext = PC_W'(ofs);
    return pc + PC_STEP + ext + ext;
  endfunction

  // ==========================================================
  // state

  // sequencer: current phase, decoded operation, latched word and the
  // dead-cycle flag that follows a call
  scx_phase_e phase_reg, phase_next;
  scx_op_e op_reg, op_next;
  logic [WORD_W-1:0] ir_reg, ir_next;
  logic flush_reg, flush_next;
  // program counter and the return stack, entry zero being the top
  logic [PC_W-1:0] pc_reg, pc_next;
  logic [PC_W-1:0] stack_reg [STACK_DEPTH];
  logic [PC_W-1:0] stack_next [STACK_DEPTH];
  // file register side: operand copy, access request, flags, reset pulse
  logic [DATA_W-1:0] operand_reg, operand_next;
  scx_freq_s freq_reg, freq_next;
  scx_flags_s flags_reg, flags_next;
  logic rst_req_reg, rst_req_next;

  // ==========================================================
  // phase sequencer and instruction latch

  // four phases per instruction cycle, the word is taken in phase one
  // the reset word cuts its own cycle short after phase two, so the next
  // word is taken at once from the restart address
  always_comb begin
    phase_next = phase_reg;
    op_next = op_reg;
    ir_next = ir_reg;
    flush_next = flush_reg;
    case (phase_reg)
      PH_Q1: begin
        phase_next = PH_Q2;
        ir_next = instr_word;
        // second call cycle executes as a no-op
        op_next = flush_reg ? OP_NOP : decode_op(instr_word);
      end
      PH_Q2: begin
        // reset restarts the cycle from phase one
        phase_next = (op_reg == OP_RESET) ? PH_Q1 : PH_Q3;
      end
      PH_Q3: begin
        phase_next = PH_Q4;
      end
      PH_Q4: begin
        phase_next = PH_Q1;
        // call always takes one extra cycle
        flush_next = (op_reg == OP_CALL);
      end
      default: begin
        phase_next = PH_Q1;
      end
    endcase
    if (phase_reg == PH_Q2 && op_reg == OP_RESET) begin
      op_next = OP_NOP;
      flush_next = 1'b0;
      ir_next = NOP_ZERO;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_reg <= PH_Q1;
      op_reg <= OP_NOP;
      ir_reg <= NOP_ZERO;
      flush_reg <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      op_reg <= op_next;
      ir_reg <= ir_next;
      flush_reg <= flush_next;
    end
  end

  // ==========================================================
  // program counter

  // updated at the end of phase four, or of phase two for the reset word, so the fetch address is steady all cycle
  // in the dead cycle after a call the counter already holds the target and
  // must not step again, otherwise the first target word would be skipped
  always_comb begin
    pc_next = pc_reg;
    if (phase_reg == PH_Q2 && op_reg == OP_RESET) begin
      // same restart value as master clear
      pc_next = PC_RESET;
    end else if (phase_reg == PH_Q4) begin
      if (op_reg == OP_CALL) begin
        // jump to pc plus two plus twice the offset
        pc_next = call_target(pc_reg, ir_reg);
      end else if (!flush_reg) begin
        pc_next = pc_reg + PC_STEP;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pc_reg <= PC_RESET;
    end else begin
      pc_reg <= pc_next;
    end
  end

  // ==========================================================
  // return stack

  // shift stack: entry zero is the top; the deepest entry falls off on push
  // limitation: no overflow or underflow is flagged, a pop past the bottom
  // simply brings up the zero fill
  always_comb begin
    for (int i = 0; i < STACK_DEPTH; i++) begin
      stack_next[i] = stack_reg[i];
    end
    if (phase_reg == PH_Q2 && (op_reg == OP_PUSH || op_reg == OP_CALL)) begin
      // old top moves one level down
      for (int i = STACK_DEPTH - 1; i > 0; i--) begin
        stack_next[i] = stack_reg[i - 1];
      end
      // push return address in phase two
      // call pushes its return address first
      stack_next[0] = pc_reg + PC_STEP;
    end else if (phase_reg == PH_Q3 && op_reg == OP_POP) begin
      // pop discards top in phase three
      // previous entry comes back on top
      for (int i = 0; i < STACK_DEPTH - 1; i++) begin
        stack_next[i] = stack_reg[i + 1];
      end
      stack_next[STACK_DEPTH - 1] = STACK_EMPTY;
    end else if (phase_reg == PH_Q2 && op_reg == OP_RESET) begin
      for (int i = 0; i < STACK_DEPTH; i++) begin
        stack_next[i] = STACK_EMPTY;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < STACK_DEPTH; i++) begin
        stack_reg[i] <= STACK_EMPTY;
      end
    end else begin
      for (int i = 0; i < STACK_DEPTH; i++) begin
        stack_reg[i] <= stack_next[i];
      end
    end
  end

  // ==========================================================
  // file register access and flags

  // strobes are set one edge early so each one is a flop for its whole phase
  // address and bank are held after the read so the write in phase four
  // goes back to the same register without a second decode
  // flags other than neg are computed from the read value, and neg from the
  // stored result, which keeps the adder off the other flag paths
  always_comb begin
    freq_next = freq_reg;
    operand_next = operand_reg;
    flags_next = flags_reg;
    rst_req_next = 1'b0;
    freq_next.rd_en = 1'b0;
    freq_next.wr_en = 1'b0;
    case (phase_reg)
      PH_Q1: begin
        if (!flush_reg && decode_op(instr_word) == OP_NEG) begin
          freq_next.rd_en = 1'b1;
          freq_next.addr = instr_word[FADDR_W-1:0];
          freq_next.bank_sel = instr_word[BANK_BIT];
        end
        // reset request stands during phase two
        rst_req_next = !flush_reg && decode_op(instr_word) == OP_RESET;
      end
      PH_Q2: begin
        if (op_reg == OP_RESET) begin
          freq_next = FREQ_IDLE;
          operand_next = DATA_ZERO;
          flags_next = FLAGS_RESET;
        end
      end
      PH_Q3: begin
        if (op_reg == OP_NEG) begin
          // two's complement of the read value
          operand_next = fr_rd_data;
          freq_next.wr_en = 1'b1;
          freq_next.wr_data = DATA_ZERO - fr_rd_data;
          flags_next.zero = (fr_rd_data == DATA_ZERO);
          flags_next.neg = freq_next.wr_data[DATA_W-1];
          flags_next.carry = (fr_rd_data == DATA_ZERO);
          flags_next.ovf = (fr_rd_data == DATA_MIN);
          flags_next.dcarry = (fr_rd_data[3:0] == NIBBLE_ZERO);
        end
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      freq_reg <= FREQ_IDLE;
      operand_reg <= DATA_ZERO;
      flags_reg <= FLAGS_RESET;
      rst_req_reg <= 1'b0;
    end else begin
      freq_reg <= freq_next;
      operand_reg <= operand_next;
      flags_reg <= flags_next;
      rst_req_reg <= rst_req_next;
    end
  end

  // ==========================================================
  // outputs, all straight from flops
  // no output is combined after a register, so the rest of the core sees
  // clean edges one clock after each decision
  assign program_counter = pc_reg;
  assign phase = phase_reg;
  assign fr_req = freq_reg;
  assign top_of_stack = stack_reg[0];
  assign status_flags = flags_reg;
  assign reset_instr_req = rst_req_reg;

endmodule // scx_exec

// ==== logic/scx_pkg.sv ====
// package for the stack and control instruction executor
// assumes a 16-bit program word, 8-bit file registers and a 21-bit program counter
package scx_pkg;

  // ==========================================================
  // widths and depths
  localparam int PC_W = 21;
  localparam int WORD_W = 16;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 8;
  localparam int CALL_OFS_W = 11;
  localparam int STACK_DEPTH = 8;

  // ==========================================================
  // field positions inside the instruction word
  localparam int BANK_BIT = 8;
  localparam int CALL_OFS_LSB = 0;

  // ==========================================================
  // opcode masks and match values
  localparam logic [WORD_W-1:0] NEG_MASK = 16'hFE00;
  localparam logic [WORD_W-1:0] NEG_MATCH = 16'h6C00;
  localparam logic [WORD_W-1:0] NOP_ZERO = 16'h0000;
  localparam logic [WORD_W-1:0] NOP_MASK = 16'hF000;
  localparam logic [WORD_W-1:0] NOP_MATCH = 16'hF000;
  localparam logic [WORD_W-1:0] POP_WORD = 16'h0006;
  localparam logic [WORD_W-1:0] PUSH_WORD = 16'h0005;
  localparam logic [WORD_W-1:0] RESET_WORD = 16'h00FF;
  localparam logic [WORD_W-1:0] CALL_MASK = 16'hF800;
  localparam logic [WORD_W-1:0] CALL_MATCH = 16'hD800;

  // ==========================================================
  // reset values and steps
  localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
  localparam logic [PC_W-1:0] STACK_EMPTY = 21'h000000;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
  localparam logic [DATA_W-1:0] DATA_MIN = 8'h80;
  localparam logic [3:0] NIBBLE_ZERO = 4'h0;

  // ==========================================================
  // types
  typedef enum logic [3:0] {
    PH_Q1 = 4'h1,
    PH_Q2 = 4'h2,
    PH_Q3 = 4'h4,
    PH_Q4 = 4'h8
  } scx_phase_e;

  typedef enum logic [2:0] {
    OP_NOP = 3'h0,
    OP_NEG = 3'h1,
    OP_POP = 3'h2,
    OP_PUSH = 3'h3,
    OP_CALL = 3'h4,
    OP_RESET = 3'h5
  } scx_op_e;

  typedef struct packed {
    logic rd_en;
    logic wr_en;
    logic bank_sel;
    logic [FADDR_W-1:0] addr;
    logic [DATA_W-1:0] wr_data;
  } scx_freq_s;

  typedef struct packed {
    logic neg;
    logic ovf;
    logic carry;
    logic dcarry;
    logic zero;
  } scx_flags_s;

  localparam scx_freq_s FREQ_IDLE = '0;
  localparam scx_flags_s FLAGS_RESET = '0;

endpackage : scx_pkg

// ==== sim/scx_exec_asserts.sv ====
// checker for the stack and control executor, watching its ports only
// assumes scx_pkg and scx_exec are compiled first; bound below
`timescale 1ns/1ps

module scx_exec_chk
  import scx_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // program memory
  input wire logic [WORD_W-1:0] instr_word,
  input wire logic [PC_W-1:0] program_counter,
  input wire scx_phase_e phase,
  // file register access
  input wire logic [DATA_W-1:0] fr_rd_data,
  input wire scx_freq_s fr_req,
  // core state
  input wire logic [PC_W-1:0] top_of_stack,
  input wire scx_flags_s status_flags,
  input wire logic reset_instr_req
);
  // ==========================================================
  // helpers: the word in a call's dead cycle is not an instruction
  logic dead_reg;
  logic dead_next;
  logic take;
  logic is_call;
  logic plain;
  logic [PC_W-1:0] call_tgt;
  assign take = (phase == PH_Q1) && !dead_reg;
  assign is_call = (instr_word & CALL_MASK) == CALL_MATCH;
  assign plain = instr_word == NOP_ZERO || (instr_word & NOP_MASK) == NOP_MATCH || instr_word == POP_WORD
    || instr_word == PUSH_WORD;
  assign call_tgt = program_counter + PC_STEP + {{(PC_W-12){instr_word[10]}}, instr_word[10:0], 1'h0};
  // dead flag follows each taken call for one instruction cycle
  always_comb begin
    dead_next = dead_reg;
    if (phase == PH_Q1) begin
      dead_next = take && is_call;
    end
  end
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) dead_reg <= 1'h0;
    else dead_reg <= dead_next;
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  a_neg_strobe_phase: assert property (fr_req.rd_en |-> phase == PH_Q2 ##2 fr_req.wr_en && phase == PH_Q4)
    else $error("negate strobes out of phase");
  a_neg_write_value: assert property (fr_req.wr_en |-> fr_req.wr_data == DATA_ZERO - $past(fr_rd_data))
    else $error("negate result wrong");
  a_nop_quiet: assert property (take && plain |=> (!fr_req.rd_en && !fr_req.wr_en && $stable(status_flags))[*4])
    else $error("plain word touched registers or flags");
  a_plain_pc_step: assert property (take && plain |-> ##4 program_counter == $past(program_counter, 4) + PC_STEP)
    else $error("plain word pc step wrong");
  a_push_tos_value: assert property (take && (instr_word == PUSH_WORD || is_call)
    |-> ##2 top_of_stack == $past(program_counter, 2) + PC_STEP)
    else $error("pushed return address wrong");
  a_pop_tos_hold: assert property (take && instr_word == POP_WORD |=> $stable(top_of_stack)[*2])
    else $error("pop changed stack before q3");
  a_call_target: assert property (take && is_call |-> ##4 program_counter == $past(call_tgt, 4))
    else $error("call target wrong");
  a_call_dead_pc: assert property (take && is_call |-> ##5 $stable(program_counter)[*4])
    else $error("pc moved in call dead cycle");
  a_call_flags: assert property (take && is_call |=> $stable(status_flags)[*8])
    else $error("call changed flags");
  a_reset_start: assert property (take && instr_word == RESET_WORD |=> reset_instr_req
    ##1 (phase == PH_Q1 && program_counter == PC_RESET && top_of_stack == STACK_EMPTY))
    else $error("reset word did not reset");
  // main scenarios reached
  c_call: cover property (take && is_call);
  c_neg: cover property (fr_req.wr_en);
  c_reset: cover property (reset_instr_req);
endmodule // scx_exec_chk

bind scx_exec scx_exec_chk u_chk (.core_clk(core_clk), .rst_b(rst_b), .instr_word(instr_word),
  .program_counter(program_counter), .phase(phase), .fr_rd_data(fr_rd_data), .fr_req(fr_req),
  .top_of_stack(top_of_stack), .status_flags(status_flags), .reset_instr_req(reset_instr_req));

// ==== sim/tb_top.sv ====
// bench for the stack and control executor: negate table, then hand tests
// assumes scx_pkg, scx_exec and its checker are compiled first
`timescale 1ns/1ps

module tb_top
  import scx_pkg::*;
;
  // ==========================================================
  // signals and expectations
  typedef struct packed {
    logic [WORD_W-1:0] w;
    logic [DATA_W-1:0] d;
    logic [DATA_W-1:0] e;
  } scx_row_s;
  scx_row_s rows [5] = '{'{16'h6C12, 8'h3A, 8'hC6}, '{16'h6D34, 8'h00, 8'h00}, '{16'h6C00, 8'h80, 8'h80},
    '{16'h6DFF, 8'h01, 8'hFF}, '{16'h6C55, 8'hF0, 8'h10}};
  logic [10:0] offs [3] = '{11'h3FF, 11'h400, 11'h7FD};
  logic core_clk;
  logic rst_b;
  logic [WORD_W-1:0] instr_word;
  logic [DATA_W-1:0] fr_rd_data;
  logic [PC_W-1:0] program_counter;
  logic [PC_W-1:0] top_of_stack;
  logic [PC_W-1:0] exp_pc;
  logic [PC_W-1:0] ret;
  scx_phase_e phase;
  scx_freq_s fr_req;
  scx_freq_s q4_req;
  scx_flags_s status_flags;
  scx_flags_s ef;
  logic reset_instr_req;
  logic q2_rd;
  int err_total = 0;
  int n_compared = 0;
  int cyc = 0;

  scx_exec dut (.core_clk(core_clk), .rst_b(rst_b), .instr_word(instr_word),
    .program_counter(program_counter), .phase(phase), .fr_rd_data(fr_rd_data), .fr_req(fr_req),
    .top_of_stack(top_of_stack), .status_flags(status_flags), .reset_instr_req(reset_instr_req));

  // ==========================================================
  // clock and hang guard
  initial begin
    core_clk = 1'h0;
    forever #2.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 1000) begin
      err_total = err_total + 1;
      results();
    end
  end

  // ==========================================================
  // tasks
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge core_clk);
      #1;
    end
  endtask
  task automatic chk(input logic [PC_W-1:0] g, input logic [PC_W-1:0] e);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  // one instruction cycle; read data is valid in q3 only, inverted from q4 on
  task automatic issue(input logic [WORD_W-1:0] w, input logic [DATA_W-1:0] d);
    instr_word = w;
    tick(1);
    q2_rd = fr_req.rd_en;
    tick(1);
    fr_rd_data = d;
    tick(1);
    q4_req = fr_req;
    fr_rd_data = ~d;
    tick(1);
  endtask
  task automatic results();
    if (err_total == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    rst_b = 1'h0;
    instr_word = NOP_ZERO;
    fr_rd_data = DATA_ZERO;
    tick(5);
    rst_b = 1'h1;
    // state after master clear
    chk(phase, PH_Q1);
    chk(program_counter, PC_RESET);
    chk(top_of_stack, STACK_EMPTY);
    chk(fr_req, FREQ_IDLE);
    exp_pc = PC_RESET;
    foreach (rows[i]) begin
      issue(rows[i].w, rows[i].d);
      exp_pc = exp_pc + PC_STEP;
      ef = {rows[i].e[7], rows[i].d == 8'h80, rows[i].d == 8'h00, rows[i].d[3:0] == 4'h0, rows[i].d == 8'h00};
      chk(q2_rd, 1'h1);
      chk(q4_req.wr_en, 1'h1);
      chk(q4_req.addr, rows[i].w[7:0]);
      chk(q4_req.bank_sel, rows[i].w[BANK_BIT]);
      chk(q4_req.wr_data, rows[i].e);
      chk(status_flags, ef);
      chk(program_counter, exp_pc);
    end
    // both no-op forms; flags from the last negate must survive
    issue(NOP_ZERO, 8'h5A);
    issue(16'hF3C1, 8'h5A);
    exp_pc = exp_pc + 21'h000004;
    chk(program_counter, exp_pc);
    chk(status_flags, ef);
    chk(q4_req.wr_en, 1'h0);
    // two pushes, then pops down to the zero fill
    issue(PUSH_WORD, DATA_ZERO);
    ret = exp_pc + PC_STEP;
    exp_pc = ret;
    chk(top_of_stack, ret);
    issue(PUSH_WORD, DATA_ZERO);
    chk(top_of_stack, exp_pc + PC_STEP);
    issue(POP_WORD, DATA_ZERO);
    exp_pc = exp_pc + 21'h000004;
    chk(top_of_stack, ret);
    chk(program_counter, exp_pc);
    chk(status_flags, ef);
    issue(POP_WORD, DATA_ZERO);
    exp_pc = exp_pc + PC_STEP;
    chk(top_of_stack, STACK_EMPTY);
    // calls at both offset limits and at -3; a pop in the dead cycle must be ignored
    foreach (offs[i]) begin
      ret = exp_pc + PC_STEP;
      issue(CALL_MATCH | {5'h00, offs[i]}, DATA_ZERO);
      exp_pc = ret + {{9{offs[i][10]}}, offs[i], 1'h0};
      chk(top_of_stack, ret);
      chk(program_counter, exp_pc);
      issue(POP_WORD, DATA_ZERO);
      chk(program_counter, exp_pc);
      chk(top_of_stack, ret);
      chk(status_flags, ef);
    end
    // reset word pulses in q2, then state restarts at q1
    instr_word = RESET_WORD;
    tick(1);
    chk(reset_instr_req, 1'h1);
    tick(1);
    instr_word = NOP_ZERO;
    chk(phase, PH_Q1);
    chk(program_counter, PC_RESET);
    chk(top_of_stack, STACK_EMPTY);
    chk(status_flags, FLAGS_RESET);
    tick(1);
    chk(reset_instr_req, 1'h0);
    // back to phase one, push, then master clear in mid-run
    tick(3);
    issue(PUSH_WORD, DATA_ZERO);
    chk(top_of_stack, PC_STEP + PC_STEP);
    rst_b = 1'h0;
    tick(2);
    rst_b = 1'h1;
    chk(phase, PH_Q1);
    chk(program_counter, PC_RESET);
    chk(top_of_stack, STACK_EMPTY);
    issue(NOP_ZERO, DATA_ZERO);
    chk(program_counter, PC_STEP);
    results();
  end
endmodule // tb_top
